// File: verilog/host_serial_command_port.sv
// Host serial command port: link-side shifter and system-side command hand-off
`timescale 1ns/1ps
`default_nettype none

module host_serial_command_port
   import cmd_port_pkg::*;
(
   input  wire logic        mclk_i,           // System clock, 20 MHz
   input  wire logic        sys_rst_i,        // Asynchronous reset, active high
   input  wire logic        serial_clk_i,     // Serial clock from host (link domain)
   input  wire logic        chip_select_n_i,  // Active-low chip select from host
   input  wire logic        command_data_in_i,// Command data from host
   output logic             reply_data_o,     // Reply data toward host
   output logic             reply_data_oe_o,  // Reply data output enable, high drives
   input  wire logic [7:0]  reply_byte_i,     // Reply byte from device core
   output logic             reply_load_o,     // Pulse: reply byte taken for the frame just started
   output logic             cmd_valid_o,      // Pulse: command complete
   output logic [7:0]       cmd_byte0_o,      // First command byte
   output logic [7:0]       cmd_byte1_o,      // Second command byte
   output logic [1:0]       cmd_nbytes_o      // Whole bytes received in the frame, capped at two
);

   //------------------------------------------------------------
   // Link domain
   //------------------------------------------------------------
   // Chip select high resets the link logic asynchronously. That frames each
   // command without needing serial clock edges outside a frame, and lets the
   // serial clock idle at either level: only rising edges inside a frame count.
   logic            link_rst;
   logic [2:0]      bit_cnt;
   logic [7:0]      shift_in;
   logic [7:0]      byte0_l;
   logic [7:0]      byte1_l;
   logic [1:0]      nbytes_l;
   logic [2:0]      reply_idx;
   logic            reply_done;
   logic            reply_bit;

   assign link_rst = chip_select_n_i | sys_rst_i;

   // Bit counter, MSB position first
   always_ff @(posedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt <= BITCNT_RST;
      end else begin
         bit_cnt <= bit_cnt - 3'h1;
      end
   end

   // Input shifter: first bit lands in bit 7
   always_ff @(posedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         shift_in <= CMD_RST;
      end else begin
         shift_in <= {shift_in[6:0], command_data_in_i};
      end
   end

   // Completed bytes are stored; a third byte and beyond is ignored
   always_ff @(posedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         byte0_l  <= CMD_RST;
         byte1_l  <= CMD_RST;
         nbytes_l <= NBYTES_RST;
      end else if (bit_cnt == 3'h0) begin
         if (nbytes_l == 2'h0) begin
            byte0_l <= {shift_in[6:0], command_data_in_i};
         end else if (nbytes_l == 2'h1) begin
            byte1_l <= {shift_in[6:0], command_data_in_i};
         end
         if (nbytes_l != 2'(MAX_BYTES)) begin
            nbytes_l <= nbytes_l + 2'h1;
         end
      end
   end

   // Reply bit index follows the bit counter on falling edges, so the bit
   // stays put across the host's rising-edge sample. A falling edge before
   // the first rise keeps index 7, which makes either idle level work.
   always_ff @(negedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         reply_idx <= BITCNT_RST;
      end else begin
         reply_idx <= bit_cnt;
      end
   end

   // Only one reply byte: bits after the first byte read zero
   always_ff @(negedge serial_clk_i or posedge link_rst) begin
      if (link_rst) begin
         reply_done <= 1'b0;
      end else begin
         reply_done <= (nbytes_l != NBYTES_RST);
      end
   end

   // The core holds the reply byte static across the frame
   assign reply_bit = reply_done ? 1'b0 : reply_byte_i[reply_idx];

   // Reply enable follows select directly: released within gate delay
   assign reply_data_o    = reply_bit & ~chip_select_n_i;
   assign reply_data_oe_o = ~chip_select_n_i;

   //------------------------------------------------------------
   // Crossing to the system clock
   //------------------------------------------------------------
   // Select is synchronised as a level; its rising edge marks command end.
   // The byte registers are stable once select is high (link logic held),
   // but they reset at that moment, so each completed byte is also copied
   // into hold registers in the link domain that select does not reset.
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
      end else begin
         cs_meta <= chip_select_n_i;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
      end
   end

   // Holding copy of the latest complete bytes, clocked on each byte end in
   // the link domain and not reset by select, so it survives the frame end.
   logic [7:0] hold0;
   logic [7:0] hold1;
   logic [1:0] hold_n;

   always_ff @(posedge serial_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold0  <= CMD_RST;
         hold1  <= CMD_RST;
         hold_n <= NBYTES_RST;
      end else if (!chip_select_n_i && bit_cnt == 3'h0) begin
         if (nbytes_l == 2'h0) begin
            hold0  <= {shift_in[6:0], command_data_in_i};
            hold1  <= CMD_RST;
            hold_n <= 2'h1;
         end else if (nbytes_l == 2'h1) begin
            hold1  <= {shift_in[6:0], command_data_in_i};
            hold_n <= 2'h2;
         end
      end else if (!chip_select_n_i && bit_cnt == BITCNT_RST && nbytes_l == 2'h0) begin
         hold_n <= NBYTES_RST;   // New frame: forget the previous count
      end
   end

   // Command hand-off: hold registers are quiet while select is high,
   // so sampling them after the synchronised select rise is safe.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_valid_o  <= 1'b0;
         cmd_byte0_o  <= CMD_RST;
         cmd_byte1_o  <= CMD_RST;
         cmd_nbytes_o <= NBYTES_RST;
      end else begin
         cmd_valid_o <= 1'b0;
         if (cs_sync && !cs_prev) begin
            cmd_valid_o  <= 1'b1;
            cmd_byte0_o  <= hold0;
            cmd_byte1_o  <= hold1;
            cmd_nbytes_o <= hold_n;
         end
      end
   end

   // Tell the core when a new frame has started using its reply byte
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reply_load_o <= 1'b0;
      end else begin
         reply_load_o <= !cs_sync && cs_prev;
      end
   end

   // Unused bookkeeping copies, reduced into a signal that nothing reads
   logic unused_link;
   assign unused_link = ^{byte0_l, byte1_l};

endmodule : host_serial_command_port

`default_nettype wire

// File: verilog/cmd_port_pkg.sv
// Constants shared by the host serial command port
//------------------------------------------------------------
// What this block does
// - Commands carry one or two bytes, each shifted MSB first, LSB last.
// - Reply bytes leave the device on the reply line MSB first, LSB last.
// - Command data bits are captured on serial clock rising edges while selected.
// - A received command is acted on only when chip select rises.
// - Serial clock may idle high or low; either polarity works.
// - Reply output is released within 1.0 us after chip select returns high.
//------------------------------------------------------------
package cmd_port_pkg;

   // Byte width, most bytes per command and bit counter width
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned MAX_BYTES     = 2;
   localparam int unsigned BITCNT_W      = 3;
   // Reply release limit in ns and the system clock period in ns
   localparam int unsigned HIZ_MAX_NS    = 1000;
   localparam int unsigned MCLK_NS       = 50;
   // Longest time rounds down; release is combinational and uses none of this budget
   localparam int unsigned HIZ_CYCLES    = HIZ_MAX_NS / MCLK_NS;
   // Reset values
   localparam logic [7:0]  CMD_RST       = 8'h00;
   localparam logic [2:0]  BITCNT_RST    = 3'h7;
   localparam logic [1:0]  NBYTES_RST    = 2'h0;

endpackage : cmd_port_pkg

// File: verif/cmd_port_monitor.sv
// Checker on the command port's top-level ports
`timescale 1ns/1ps
`default_nettype none
module cmd_port_monitor (
   input wire logic       mclk_i,          // Clock
   input wire logic       sys_rst_i,       // Reset
   input wire logic       chip_select_n_i, // Select
   input wire logic       reply_data_o,    // Reply bit
   input wire logic       reply_data_oe_o, // Reply enable
   input wire logic [7:0] reply_byte_i,    // Reply byte
   input wire logic       cmd_valid_o,     // Done pulse
   input wire logic [7:0] cmd_byte0_o,     // First byte
   input wire logic [1:0] cmd_nbytes_o     // Byte count
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Release has to be prompt; a late release would fight the next device
   a_oe_follows_sel: assert property (reply_data_oe_o == !chip_select_n_i)
      else $error("reply enable does not follow select");
   a_release_done: assert property ($rose(chip_select_n_i) |-> !reply_data_oe_o)
      else $error("reply still driven after select release");
   a_msb_first: assert property ($fell(chip_select_n_i) |-> reply_data_o == reply_byte_i[7])
      else $error("first reply bit is not bit 7");
   a_valid_after_end: assert property ($rose(chip_select_n_i) |-> ##[2:4] cmd_valid_o)
      else $error("no command pulse after select release");
   a_valid_only_idle: assert property (cmd_valid_o |-> $past(chip_select_n_i) && !$past(cmd_valid_o))
      else $error("command pulse while selected or too long");
   a_bytes_hold: assert property (!cmd_valid_o |-> $stable(cmd_byte0_o) && $stable(cmd_nbytes_o))
      else $error("command bytes changed without a pulse");
   a_count_range: assert property (cmd_valid_o |-> cmd_nbytes_o <= 2'h2)
      else $error("byte count above two");
   c_two_bytes: cover property (cmd_valid_o && cmd_nbytes_o == 2'h2);
   c_one_byte: cover property (cmd_valid_o && cmd_nbytes_o == 2'h1);
   c_frame_start: cover property ($fell(chip_select_n_i));
endmodule : cmd_port_monitor
bind host_serial_command_port cmd_port_monitor mon_u (.*);
`default_nettype wire

// File: verif/host_master_model.sv
// Host serial master model that frames commands and reads the reply
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
   output var logic sclk_o,  // Serial clock
   output var logic csn_o,   // Select, active low
   output var logic data_o,  // Command data
   input wire logic reply_i, // Reply bit
   input wire logic oe_i     // Reply enable
);
   // Deselected and parked at start
   initial begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      data_o = 1'b0;
   end
   // Clock is parked while deselected so no stray edge lands inside a frame
   task automatic frame(input logic [23:0] d, input int nb, input bit idle,
                        output logic [7:0] rep);
      rep = 8'h00;
      sclk_o = idle;
      #50;
      csn_o = 1'b0;
      #100;
      for (int i = 0; i < nb; i++) begin
         sclk_o = 1'b0;
         data_o = d[23 - i];
         #6;
         sclk_o = 1'b1;
         if (i < 8) rep[7 - i] = oe_i ? reply_i : 1'bx;
         #6;
      end
      sclk_o = idle;
      #100;
      csn_o = 1'b1;
      data_o = ~data_o; // Released line shows no stale bit
   endtask : frame
endmodule : host_master_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: random framed commands through the command port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i, sys_rst_i, sclk, chip_select_n, cdat, reply, oe, load, valid;
   logic [7:0]  rbyte, b0, b1, rep;
   logic [1:0]  nb_o;
   logic [31:0] seed = 32'hFC21CC06;
   logic [23:0] d;
   int          err_total = 0, n_checks = 0, cycles = 0, nb, loads = 0;
   int          nbits[6] = '{8, 16, 12, 20, 16, 8}; // Partial and overlong frames too
   host_serial_command_port dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .serial_clk_i(sclk),
      .chip_select_n_i(chip_select_n), .command_data_in_i(cdat), .reply_data_o(reply),
      .reply_data_oe_o(oe), .reply_byte_i(rbyte), .reply_load_o(load), .cmd_valid_o(valid),
      .cmd_byte0_o(b0), .cmd_byte1_o(b1), .cmd_nbytes_o(nb_o));
   host_master_model host_u (.sclk_o(sclk), .csn_o(chip_select_n), .data_o(cdat), .reply_i(reply),
      .oe_i(oe));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // Hang guard, far above twelve frames of about forty cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   // One reply-load pulse is expected per frame
   always @(posedge mclk_i) begin
      if (load === 1'b1) loads++;
   end
   // Idle level alternates each frame; trailing partial bytes must be dropped
   initial begin
      sys_rst_i = 1'b1;
      rbyte = 8'h00;
      repeat (10) @(posedge mclk_i);
      @(negedge mclk_i) sys_rst_i = 1'b0;
      for (int k = 0; k < 12; k++) begin
         @(negedge mclk_i);
         seed = xs(seed);
         rbyte = seed[7:0];
         d = (k == 0) ? 24'h80FF01 : seed[31:8];
         nb = nbits[k % 6];
         host_u.frame(d, nb, k[0], rep);
         #1;
         check("reply", rep, rbyte);
         check("oe", oe, 0);
         for (int w = 0; w < 8 && valid !== 1'b1; w++) @(posedge mclk_i) #1;
         check("valid", valid, 1);
         check("byte0", b0, d[23:16]);
         check("byte1", b1, (nb >= 16) ? d[15:8] : 8'h00);
         check("nbytes", nb_o, (nb >= 16) ? 2'h2 : 2'h1);
         repeat (24) @(negedge mclk_i);
      end
      check("loads", loads, 12);
      conclude();
   end
endmodule : testbench
`default_nettype wire
